// ### hdl/hdma_pkg.sv
/*
 * Shared constants for the host memory port: bus widths, latch word
 * layout, reserved control-register window, boot strap code and the
 * register windows of the host-side controller.
 * Assumes a single 100 MHz clock domain on both ends.
 */
package hdma_pkg;

   // ----------------------------------------------------------------
   // widths and latch word layout
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 14;
   localparam int          DATA_W         = 16;
   localparam int          OPCODE_W       = 24;
   localparam int          OVL_SEL_BIT    = 15;
   localparam int          TYPE_BIT       = 14;

   // ----------------------------------------------------------------
   // processor data-space map
   // ----------------------------------------------------------------
   localparam logic [13:0] CTL_REG_LO     = 14'h3FE0;
   localparam logic [13:0] CTL_REG_HI     = 14'h3FFF;
   localparam logic [13:0] OVERLAY_ADDR   = 14'h3FE0;
   localparam logic [13:0] ADDR_CTL_ADDR  = 14'h3FE1;
   localparam logic [15:0] OVERLAY_RST    = 16'h0000;
   localparam logic [13:0] RESTART_ADDR   = 14'h0000;

   // mode pins packed as {d, c, b, a}
   localparam logic [3:0]  PORT_BOOT_MODE = 4'h5;

   // ----------------------------------------------------------------
   // host side: microcontroller addresses and register windows
   // ----------------------------------------------------------------
   localparam logic [15:0] HOST_BASE      = 16'h2000;
   localparam logic [15:0] HOST_LATCH     = 16'h2002;
   localparam logic [1:0]  AVL_DATA       = 2'h0;
   localparam logic [1:0]  AVL_LATCH      = 2'h1;
   localparam logic [1:0]  AVL_STATUS     = 2'h2;
   localparam logic [2:0]  HOST_GAP       = 3'h4;

endpackage : hdma_pkg

// ### hdl/host_dma_if.sv
/*
 * Pin-level carrier between the host controller and the memory port.
 * Each end drives its copy of the shared bus with an active-low enable;
 * the resolved level is worked out here, idle high as with pull-ups.
 */
`timescale 1ns/10ps
`default_nettype none

interface host_dma_if;
   logic [15:0] host_bus_o;
   logic        host_bus_oe_n;
   logic [15:0] dev_bus_o;
   logic        dev_bus_oe_n;
   logic [15:0] host_addr_data_bus;
   logic        host_port_select_n;
   logic        address_latch_input;
   logic        host_read_strobe_n;
   logic        host_write_strobe_n;
   logic        host_port_acknowledge_n;

   assign host_addr_data_bus = !host_bus_oe_n ? host_bus_o :
                               !dev_bus_oe_n  ? dev_bus_o  : 16'hFFFF;

   modport dev_mp (
      input  host_addr_data_bus,
      input  host_port_select_n,
      input  address_latch_input,
      input  host_read_strobe_n,
      input  host_write_strobe_n,
      output dev_bus_o,
      output dev_bus_oe_n,
      output host_port_acknowledge_n
   );

   modport host_mp (
      input  host_addr_data_bus,
      input  host_port_acknowledge_n,
      output host_bus_o,
      output host_bus_oe_n,
      output host_port_select_n,
      output address_latch_input,
      output host_read_strobe_n,
      output host_write_strobe_n
   );
endinterface : host_dma_if

`default_nettype wire

// ### hdl/host_dma_memory_port.sv
/*
 * Device end of the host memory port: internal program and data memory,
 * address latch, overlay register, auto increment, 24-bit opcode split
 * and port boot control.
 * Assumes host pins are asynchronous to sys_clk and the processor core
 * reaches data space through the cpu_mem_* port on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module host_dma_memory_port #(
   parameter int PROG_WORDS = 16384,
   parameter int DATA_WORDS = 16384
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   host_dma_if.dev_mp       port_if,
   input  wire logic [13:0] cpu_mem_addr,
   input  wire logic        cpu_mem_rd,
   input  wire logic        cpu_mem_wr,
   input  wire logic [15:0] cpu_mem_wdata,
   output logic      [15:0] cpu_mem_rdata,
   input  wire logic [3:0]  mode_pins,
   output logic             ext_bus_en,
   output logic             core_run,
   output logic      [15:0] overlay_sel
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_ctl_reg(input logic [13:0] a);
      is_ctl_reg = (a >= hdma_pkg::CTL_REG_LO) && (a <= hdma_pkg::CTL_REG_HI);
   endfunction : is_ctl_reg

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_ACCESS = 3'b010,
      ST_DONE   = 3'b100
   } port_state_t;

   localparam logic [19:0] SYNC_IDLE = {1'b1, 1'b0, 1'b1, 1'b1, 16'h0000};

   logic [19:0]  sync1_q;
   logic [19:0]  sync2_q;
   logic [3:0]   mode1_q;
   logic [3:0]   mode2_q;
   port_state_t  state_q;
   logic         ack_n_q;
   logic         oe_n_q;
   logic [15:0]  dout_q;
   logic [13:0]  addr_q;
   logic         type_q;
   logic         half_q;
   logic [15:0]  hi_buf_q;
   logic [15:0]  overlay_q;
   logic [15:0]  cpu_rdata_q;
   logic         strap_done_q;
   logic         ext_en_q;
   logic         run_q;
   localparam int OPC_W = hdma_pkg::OPCODE_W;
   logic [OPC_W-1:0] prog_mem [0:PROG_WORDS-1];
   logic [15:0]  data_mem [0:DATA_WORDS-1];

   logic         sel_n_s;
   logic         ale_s;
   logic         rd_n_s;
   logic         wr_n_s;
   logic [15:0]  bus_s;
   logic         req;
   logic         latch_cyc;
   logic         rd_cyc;
   logic         wr_cyc;
   logic         h_latch;
   logic         h_rd;
   logic         h_wr;

   // ----------------------------------------------------------------
   // pin synchronisers: strobes and bus together
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= {port_if.host_port_select_n, port_if.address_latch_input,
                     port_if.host_read_strobe_n, port_if.host_write_strobe_n,
                     port_if.host_addr_data_bus};
         sync2_q <= sync1_q;
      end
   end

   assign sel_n_s   = sync2_q[19];
   assign ale_s     = sync2_q[18];
   assign rd_n_s    = sync2_q[17];
   assign wr_n_s    = sync2_q[16];
   assign bus_s     = sync2_q[15:0];
   // only host-driven cycles are acted on; nothing here starts one
   assign req       = !sel_n_s && (ale_s || !rd_n_s || !wr_n_s);
   // latch cycles keep the write strobe high, so the latch line decides
   assign latch_cyc = ale_s && rd_n_s;
   assign rd_cyc    = !ale_s && !rd_n_s;
   assign wr_cyc    = !ale_s && !wr_n_s && rd_n_s;
   assign h_latch   = (state_q == ST_ACCESS) && latch_cyc;
   assign h_rd      = (state_q == ST_ACCESS) && rd_cyc;
   assign h_wr      = (state_q == ST_ACCESS) && wr_cyc;

   // ----------------------------------------------------------------
   // handshake: ack high while busy, low once done or ready
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         ack_n_q <= 1'b0;
         oe_n_q  <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req) begin
                  ack_n_q <= 1'b1;
                  state_q <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               ack_n_q <= 1'b0;
               oe_n_q  <= !rd_cyc;
               state_q <= ST_DONE;
            end
            ST_DONE: begin
               // wait for release so one strobe is one access
               if (!req) begin
                  oe_n_q  <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // address, type, half and overlay registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         addr_q    <= 14'h0000;
         type_q    <= 1'b0;
         half_q    <= 1'b0;
         overlay_q <= hdma_pkg::OVERLAY_RST;
         hi_buf_q  <= 16'h0000;
      end else begin
         if (h_latch) begin
            if (bus_s[hdma_pkg::OVL_SEL_BIT]) begin
               overlay_q <= bus_s;
            end else begin
               addr_q <= bus_s[13:0];
               type_q <= bus_s[hdma_pkg::TYPE_BIT];
               half_q <= 1'b0;
            end
         end else if (h_rd || h_wr) begin
            if (type_q) begin
               half_q <= !half_q;
               if (half_q) begin
                  addr_q <= addr_q + 14'h0001;
               end else if (h_wr) begin
                  hi_buf_q <= bus_s;
               end
            end else begin
               addr_q <= addr_q + 14'h0001;
            end
         end
         // processor side wins over a host update in the same cycle
         if (cpu_mem_wr) begin
            if (cpu_mem_addr == hdma_pkg::OVERLAY_ADDR) begin
               overlay_q <= cpu_mem_wdata;
            end else if (cpu_mem_addr == hdma_pkg::ADDR_CTL_ADDR) begin
               addr_q <= cpu_mem_wdata[13:0];
               type_q <= cpu_mem_wdata[hdma_pkg::TYPE_BIT];
               half_q <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // memories: control-register window is never touched by the host
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (h_wr) begin
         if (type_q) begin
            if (half_q) begin
               prog_mem[addr_q] <= {hi_buf_q, bus_s[7:0]};
            end
         end else if (!is_ctl_reg(addr_q)) begin
            data_mem[addr_q] <= bus_s;
         end
      end
      if (cpu_mem_wr && !is_ctl_reg(cpu_mem_addr)) begin
         data_mem[cpu_mem_addr] <= cpu_mem_wdata;
      end
   end

   // host reads return memory, or zero in the control-register window, never the latched address
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         dout_q <= 16'h0000;
      end else if (h_rd) begin
         if (type_q) begin
            dout_q <= half_q ? {8'h00, prog_mem[addr_q][7:0]} : prog_mem[addr_q][OPC_W-1:8];
         end else if (is_ctl_reg(addr_q)) begin
            dout_q <= 16'h0000;
         end else begin
            dout_q <= data_mem[addr_q];
         end
      end
   end

   // ----------------------------------------------------------------
   // processor data-space reads
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cpu_rdata_q <= 16'h0000;
      end else if (cpu_mem_rd) begin
         if (cpu_mem_addr == hdma_pkg::OVERLAY_ADDR) begin
            cpu_rdata_q <= overlay_q;
         end else if (cpu_mem_addr == hdma_pkg::ADDR_CTL_ADDR) begin
            cpu_rdata_q <= {1'b0, type_q, addr_q};
         end else if (is_ctl_reg(cpu_mem_addr)) begin
            cpu_rdata_q <= 16'h0000;
         end else begin
            cpu_rdata_q <= data_mem[cpu_mem_addr];
         end
      end
   end

   // ----------------------------------------------------------------
   // boot: strap caught on the first cycle after reset release
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      mode1_q <= mode_pins;
      mode2_q <= mode1_q;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         strap_done_q <= 1'b0;
         ext_en_q     <= 1'b0;
         run_q        <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         ext_en_q     <= (mode2_q != hdma_pkg::PORT_BOOT_MODE);
         run_q        <= (mode2_q != hdma_pkg::PORT_BOOT_MODE);
      end else if (h_wr && type_q && half_q && addr_q == hdma_pkg::RESTART_ADDR) begin
         run_q <= 1'b1;
      end
   end

   assign port_if.host_port_acknowledge_n = ack_n_q;
   assign port_if.dev_bus_o               = dout_q;
   assign port_if.dev_bus_oe_n            = oe_n_q;
   assign cpu_mem_rdata                   = cpu_rdata_q;
   // external bus stays off from reset onward when booting through the port
   assign ext_bus_en                      = ext_en_q;
   assign core_run                        = run_q;
   assign overlay_sel                     = overlay_q;

endmodule : host_dma_memory_port

`default_nettype wire

// ### hdl/host_port_master.sv
/*
 * Host end: microcontroller bus with its glue decode, driven from an
 * Avalon-MM slave (with waitrequest) that software uses to issue port
 * data cycles and address latch cycles.
 * Assumes the acknowledge and bus pins are asynchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module host_port_master (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   host_dma_if.host_mp      port_if,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);

   // returns {select_n, latch, read_n, write_n}
   function automatic logic [3:0] glue(input logic strobe_n, input logic rw, input logic [15:0] a);
      glue = {strobe_n | a[12] | !a[13],
              a[1],
              !rw,
              rw | a[1]};
   endfunction : glue

   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_ARM  = 5'b00010,
      H_BUSY = 5'b00100,
      H_FIN  = 5'b01000,
      H_DONE = 5'b10000
   } host_state_t;

   host_state_t state_q;
   logic [16:0] sync1_q;
   logic [16:0] sync2_q;
   logic        rw_q;
   logic [15:0] haddr_q;
   logic [15:0] wdata_q;
   logic [3:0]  pins_q;
   logic        oe_n_q;
   logic [2:0]  gap_q;
   logic [31:0] rdata_q;
   logic        wait_q;
   logic        ack_s;

   // ----------------------------------------------------------------
   // acknowledge and bus synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sync1_q <= 17'h10000;
         sync2_q <= 17'h10000;
      end else begin
         sync1_q <= {port_if.host_port_acknowledge_n, port_if.host_addr_data_bus};
         sync2_q <= sync1_q;
      end
   end

   assign ack_s = sync2_q[16];

   // ----------------------------------------------------------------
   // bus cycle sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q <= H_IDLE;
         rw_q    <= 1'b1;
         haddr_q <= hdma_pkg::HOST_BASE;
         wdata_q <= 16'h0000;
         pins_q  <= glue(1'b1, 1'b1, hdma_pkg::HOST_BASE);
         oe_n_q  <= 1'b1;
         gap_q   <= 3'h0;
         rdata_q <= 32'h0000_0000;
         wait_q  <= 1'b1;
      end else begin
         if (gap_q != 3'h0) begin
            gap_q <= gap_q - 3'h1;
         end
         case (state_q)
            H_IDLE: begin
               wait_q <= 1'b1;
               if (avs_read || avs_write) begin
                  if (avs_address == hdma_pkg::AVL_DATA ||
                      (avs_address == hdma_pkg::AVL_LATCH && avs_write)) begin
                     rw_q    <= avs_read;
                     haddr_q <= (avs_address == hdma_pkg::AVL_LATCH) ? hdma_pkg::HOST_LATCH
                                                                   : hdma_pkg::HOST_BASE;
                     wdata_q <= avs_writedata[15:0];
                     state_q <= H_ARM;
                  end else begin
                     rdata_q <= (avs_read && avs_address == hdma_pkg::AVL_STATUS) ?
                                {31'h0000_0000, ack_s} : 32'h0000_0000;
                     wait_q  <= 1'b0;
                     state_q <= H_DONE;
                  end
               end
            end
            H_ARM: begin
               // acknowledge must read low before a cycle starts
               if (!ack_s && gap_q == 3'h0) begin
                  pins_q  <= glue(1'b0, rw_q, haddr_q);
                  oe_n_q  <= rw_q;
                  state_q <= H_BUSY;
               end
            end
            H_BUSY: begin
               if (ack_s) begin
                  state_q <= H_FIN;
               end
            end
            H_FIN: begin
               if (!ack_s) begin
                  rdata_q <= {16'h0000, sync2_q[15:0]};
                  pins_q  <= glue(1'b1, 1'b1, hdma_pkg::HOST_BASE);
                  oe_n_q  <= 1'b1;
                  gap_q   <= hdma_pkg::HOST_GAP;
                  wait_q  <= 1'b0;
                  state_q <= H_DONE;
               end
            end
            H_DONE: begin
               wait_q  <= 1'b1;
               state_q <= H_IDLE;
            end
            default: begin
               state_q <= H_IDLE;
            end
         endcase
      end
   end

   assign port_if.host_port_select_n  = pins_q[3];
   assign port_if.address_latch_input = pins_q[2];
   assign port_if.host_read_strobe_n  = pins_q[1];
   assign port_if.host_write_strobe_n = pins_q[0];
   assign port_if.host_bus_o          = wdata_q;
   assign port_if.host_bus_oe_n       = oe_n_q;
   assign avs_readdata                = rdata_q;
   assign avs_waitrequest             = wait_q;

endmodule : host_port_master

`default_nettype wire

// ### verification/host_dma_props.sv
/*
 * Concurrent checks on the pins between host controller and memory port.
 * Assumes one sys_clk domain and nrst synchronous, active low.
 */
`timescale 1ns/10ps
`default_nettype none

module host_dma_props (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic [15:0] host_bus_o,
   input wire logic        host_bus_oe_n,
   input wire logic        dev_bus_oe_n,
   input wire logic        host_port_select_n,
   input wire logic        address_latch_input,
   input wire logic        host_read_strobe_n,
   input wire logic        host_write_strobe_n,
   input wire logic        host_port_acknowledge_n
);
   // ----------------------------------------------------------------
   // pin relations
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_no_bus_fight: assert property (!dev_bus_oe_n |-> host_bus_oe_n)
      else $error("both ends drive the bus");
   a_latch_no_write: assert property (address_latch_input |-> host_write_strobe_n)
      else $error("write strobe low in latch cycle");
   a_one_strobe: assert property (!host_port_select_n && !address_latch_input
      |-> host_read_strobe_n != host_write_strobe_n) else $error("strobes not exclusive");
   a_ack_low_first: assert property ($fell(host_port_select_n) |-> !$past(host_port_acknowledge_n))
      else $error("cycle started while busy");
   a_ack_one_cycle: assert property ($rose(host_port_acknowledge_n) |=> !host_port_acknowledge_n)
      else $error("busy longer than one cycle");
   a_ack_follows: assert property ($fell(host_port_select_n) |-> ##[2:12] $rose(host_port_acknowledge_n))
      else $error("no busy pulse after select");
   a_ack_needs_sel: assert property ($rose(host_port_acknowledge_n)
      |-> !host_port_select_n && !$past(host_port_select_n, 2)) else $error("busy without host cycle");
   a_host_bus_hold: assert property (!host_bus_oe_n && !$past(host_bus_oe_n) |-> $stable(host_bus_o))
      else $error("host bus changed mid cycle");
   a_drive_on_read: assert property ($fell(dev_bus_oe_n)
      |-> !host_read_strobe_n && !address_latch_input) else $error("device drove bus outside read");

   c_latch: cover property ($fell(host_port_select_n) && address_latch_input);
   c_read: cover property ($fell(dev_bus_oe_n));
   c_busy: cover property ($rose(host_port_acknowledge_n));
endmodule : host_dma_props

`default_nettype wire

// ### verification/testbench.sv
/*
 * Self-checking bench: Avalon master and processor port drive both ends
 * joined by the pin interface; expected read data queued, checked on answer.
 * Assumes 100 MHz sys_clk and port boot strap on the mode pins.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
   logic        sys_clk, nrst, avs_read, avs_write, cpu_mem_rd, cpu_mem_wr, cpu_rd_q;
   logic [1:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest, ext_bus_en, core_run;
   logic [13:0] cpu_mem_addr;
   logic [15:0] cpu_mem_wdata, cpu_mem_rdata, overlay_sel;
   logic [3:0]  mode_pins;
   logic [15:0] w[4];
   logic [31:0] av_q[$], cpu_q[$];
   int          fails, num_checks;

   host_dma_if bus_if ();
   host_port_master u_host_port_master (.sys_clk(sys_clk), .nrst(nrst), .port_if(bus_if.host_mp),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   host_dma_memory_port u_host_dma_memory_port (.sys_clk(sys_clk), .nrst(nrst), .port_if(bus_if.dev_mp),
      .cpu_mem_addr(cpu_mem_addr), .cpu_mem_rd(cpu_mem_rd), .cpu_mem_wr(cpu_mem_wr), .cpu_mem_wdata(cpu_mem_wdata),
      .cpu_mem_rdata(cpu_mem_rdata), .mode_pins(mode_pins), .ext_bus_en(ext_bus_en), .core_run(core_run),
      .overlay_sel(overlay_sel));
   host_dma_props u_host_dma_props (.sys_clk(sys_clk), .nrst(nrst), .host_bus_o(bus_if.host_bus_o),
      .host_bus_oe_n(bus_if.host_bus_oe_n), .dev_bus_oe_n(bus_if.dev_bus_oe_n),
      .host_port_select_n(bus_if.host_port_select_n), .address_latch_input(bus_if.address_latch_input),
      .host_read_strobe_n(bus_if.host_read_strobe_n), .host_write_strobe_n(bus_if.host_write_strobe_n),
      .host_port_acknowledge_n(bus_if.host_port_acknowledge_n));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic av(input logic [1:0] a, input logic wr, input logic [15:0] d, input logic [15:0] e);
      @(posedge sys_clk);
      if (!wr) av_q.push_back({16'h0000, e});
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= {16'h0000, d};
      // wait on the answer, never on a cycle count; a hang is the watchdog's
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : av

   task automatic cpu_op(input logic wr, input logic [13:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      if (!wr) cpu_q.push_back({16'h0000, d});
      cpu_mem_addr  <= a;
      cpu_mem_wdata <= d;
      cpu_mem_wr    <= wr;
      cpu_mem_rd    <= !wr;
      @(posedge sys_clk);
      cpu_mem_wr <= 1'b0;
      cpu_mem_rd <= 1'b0;
      @(posedge sys_clk);
   endtask : cpu_op

   task automatic give_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // clock, monitor, watchdog
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial cpu_rd_q = 1'b0;
   always @(posedge sys_clk) begin
      cpu_rd_q <= cpu_mem_rd;
      if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, av_q.pop_front());
      if (cpu_rd_q) chk({16'h0000, cpu_mem_rdata}, cpu_q.pop_front());
   end

   initial begin
      #100000;
      fails++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      {nrst, avs_read, avs_write, cpu_mem_rd, cpu_mem_wr} = '0;
      avs_address   = 2'h0;
      avs_writedata = 32'h0;
      cpu_mem_addr  = 14'h0;
      cpu_mem_wdata = 16'h0;
      mode_pins     = hdma_pkg::PORT_BOOT_MODE;
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      void'($urandom(32'h76f1));
      for (int i = 0; i < 4; i++) w[i] = 16'($urandom());
      repeat (2) @(posedge sys_clk);
      chk({30'h0, ext_bus_en, core_run}, 32'h0);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h0010, 16'h0);
      for (int i = 0; i < 4; i++) av(hdma_pkg::AVL_DATA, 1'b1, w[i], 16'h0);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h0010, 16'h0);
      for (int i = 0; i < 3; i++) av(hdma_pkg::AVL_DATA, 1'b0, 16'h0, w[i]);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h8005, 16'h0);
      chk({16'h0, overlay_sel}, 32'h8005);
      // overlay latch leaves the transfer address where it was
      av(hdma_pkg::AVL_DATA, 1'b0, 16'h0, w[3]);
      av(hdma_pkg::AVL_LATCH, 1'b0, 16'h0, 16'h0);
      cpu_op(1'b1, hdma_pkg::OVERLAY_ADDR, 16'h0003);
      chk({16'h0, overlay_sel}, 32'h3);
      cpu_op(1'b0, hdma_pkg::OVERLAY_ADDR, 16'h0003);
      // host write into the control-register window must not land
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h3FE5, 16'h0);
      av(hdma_pkg::AVL_DATA, 1'b1, w[3], 16'h0);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h3FE5, 16'h0);
      av(hdma_pkg::AVL_DATA, 1'b0, 16'h0, 16'h0);
      cpu_op(1'b1, hdma_pkg::ADDR_CTL_ADDR, 16'h0011);
      av(hdma_pkg::AVL_DATA, 1'b0, 16'h0, w[1]);
      cpu_op(1'b0, hdma_pkg::ADDR_CTL_ADDR, 16'h0012);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h4001, 16'h0);
      for (int i = 0; i < 4; i++) av(hdma_pkg::AVL_DATA, 1'b1, i[0] ? {8'h00, w[i][7:0]} : w[i], 16'h0);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h4001, 16'h0);
      for (int i = 0; i < 4; i++) av(hdma_pkg::AVL_DATA, 1'b0, 16'h0, i[0] ? {8'h00, w[i][7:0]} : w[i]);
      chk({31'h0, core_run}, 32'h0);
      av(hdma_pkg::AVL_LATCH, 1'b1, 16'h4000, 16'h0);
      av(hdma_pkg::AVL_DATA, 1'b1, w[2], 16'h0);
      av(hdma_pkg::AVL_DATA, 1'b1, 16'h0042, 16'h0);
      @(posedge sys_clk);
      chk({31'h0, core_run}, 32'h1);
      av(hdma_pkg::AVL_STATUS, 1'b0, 16'h0, 16'h0);
      av(2'h3, 1'b1, w[0], 16'h0);
      av(2'h3, 1'b0, 16'h0, 16'h0);
      repeat (4) @(posedge sys_clk);
      give_verdict();
   end
endmodule : testbench

`default_nettype wire
